// ===== rtl/hsc_regs.vh
// Register offsets, field positions and reset values for the link speed controller
`ifndef HSC_REGS_VH
`define HSC_REGS_VH
// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define HSC_CTRL_OFS 8'h00
`define HSC_CFG0_OFS 8'h04
`define HSC_CFG1_OFS 8'h08
`define HSC_STAT_OFS 8'h0c
`define HSC_ISTAT_OFS 8'h10
`define HSC_IMASK_OFS 8'h14
`define HSC_COMB_OFS 8'h18
// ------------------------------------------------------------
// Control register bits
// ------------------------------------------------------------
`define HSC_CTRL_HUFF 0
`define HSC_CTRL_LISTEN 1
`define HSC_CTRL_SUPDISP 2
`define HSC_CTRL_FEC200 3
`define HSC_CTRL_START 4
`define HSC_CTRL_ABORT 5
// ------------------------------------------------------------
// Interrupt status bits
// ------------------------------------------------------------
`define HSC_IRQ_DOWN 0
`define HSC_IRQ_UPREQ 1
`define HSC_IRQ_TMO 2
`define HSC_IRQ_ABAND 3
`define HSC_IRQ_COMB 4
`define HSC_IRQ_W 5
// ------------------------------------------------------------
// Reset values of the settings
// ------------------------------------------------------------
`define HSC_DOWN_RST 5'h06
`define HSC_UP_RST 5'h03
`define HSC_TRIES_RST 4'h2
`define HSC_ERRS_RST 8'h50
`define HSC_RPT_RST 3'h2
`define HSC_ARQ_RST 7'h05
`endif

// ===== rtl/hsc_link_ctrl.v
// HF ARQ link speed, timeout, FEC repeat, memory ARQ and compression control
// Functional notes
// - Bad frames reaching threshold drop to 100 baud
// - Upshift request after good-frame threshold met
// - Upshift attempts capped by configured limit
// - Limit exhausted: hold 100 until threshold again
// - Setup abandoned after configured unanswered attempts
// - Linked: faulty-frame count reached means timeout
// - Broadcast FEC rate selectable, 100 default
// - Each FEC character sent configured times
// - Keep up to configured frames for combining
// - Store frames failing CRC-16, not discard
// - Repeated bad frame combined with stored copies
// - Compress 7-bit data only when enabled, beneficial
// - Never compress frames holding 8-bit data
// - Listen mode receives, blocks all transmit starts
// - Supervisory info reported only when enabled
//
// Design decisions made here: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "hsc_regs.vh"

module hsc_link_ctrl #(
  parameter FRAME_W = 32,
  parameter ARQ_MAX = 120
) (
  input wire clock,
  input wire rst_b,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  output wire irq,
  input wire frame_valid,
  input wire frame_crc_ok,
  input wire frame_repeat,
  input wire [FRAME_W-1:0] frame_data,
  input wire link_attempt,
  input wire link_answer,
  output wire link_tx_enable,
  output reg link_speed_200_reg,
  output reg upshift_req_reg,
  output reg comb_valid_reg,
  output reg [FRAME_W-1:0] comb_data_reg,
  input wire tx_frame_has_8bit,
  input wire huff_gain,
  output wire huffman_use,
  output wire broadcast_fec_rate,
  input wire fec_in_valid,
  input wire [7:0] fec_in_data,
  output wire fec_in_ready,
  output reg fec_out_valid_reg,
  output reg [7:0] fec_out_data_reg,
  input wire fec_out_ready,
  input wire sup_valid,
  input wire [7:0] sup_data,
  output reg sup_out_valid_reg,
  output reg [7:0] sup_out_data_reg
);

  // ------------------------------------------------------------
  // Link states, one-hot
  // ------------------------------------------------------------
  localparam [2:0] ST_STBY = 3'b001;
  localparam [2:0] ST_SETUP = 3'b010;
  localparam [2:0] ST_LINKED = 3'b100;

  // ------------------------------------------------------------
  // Settings and state
  // ------------------------------------------------------------
  reg huffman_compress_enable_reg; // Compression allowed
  reg receive_only_listen_mode_reg; // Receive only
  reg supervisory_display_enable_reg; // Pass supervisory info
  reg broadcast_fec_rate_reg; // 1 = 200 baud
  reg [4:0] bad_frame_downshift_threshold_reg;
  reg [4:0] good_frame_upshift_threshold_reg;
  reg [3:0] upshift_attempt_limit_reg;
  reg [7:0] link_error_timeout_count_reg;
  reg [2:0] fec_char_repeat_count_reg;
  reg [6:0] memory_arq_depth_reg;
  reg [2:0] state_reg; // Link state
  reg [7:0] bad_cnt_reg; // Consecutive bad frames
  reg [4:0] good_cnt_reg; // Consecutive good frames
  reg [3:0] tries_used_reg; // Upshift attempts spent
  reg [7:0] setup_cnt_reg; // Unanswered setup attempts
  reg [6:0] stored_cnt_reg; // Failed copies held
  reg [`HSC_IRQ_W-1:0] istat_reg; // Sticky events
  reg [`HSC_IRQ_W-1:0] imask_reg; // Event enables
  reg [`HSC_IRQ_W-1:0] ev_next; // Events this cycle
  reg [FRAME_W-1:0] arq_mem [0:ARQ_MAX-1]; // Failed frame copies
  reg [7:0] ones_cnt_reg [0:FRAME_W-1]; // Per-bit count of ones
  wire [FRAME_W-1:0] majority; // Bitwise vote of stored copies
  reg fec_busy_reg; // A character is being repeated
  reg [2:0] fec_left_reg; // Sends still owed
  wire wr_stb;
  wire rd_stb;
  wire start_cmd;
  wire abort_cmd;
  wire linked;
  wire bad_frame;
  wire good_frame;
  wire [7:0] bad_cnt_next;
  wire [4:0] good_cnt_next;
  assign linked = state_reg[2];
  assign wr_stb = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0];
  assign rd_stb = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign start_cmd = wr_stb & (wb_adr_i == `HSC_CTRL_OFS) & wb_dat_i[`HSC_CTRL_START];
  assign abort_cmd = wr_stb & (wb_adr_i == `HSC_CTRL_OFS) & wb_dat_i[`HSC_CTRL_ABORT];
  assign bad_frame = linked & frame_valid & ~frame_crc_ok;
  assign good_frame = linked & frame_valid & frame_crc_ok;
  assign bad_cnt_next = bad_cnt_reg + 8'h01;
  assign good_cnt_next = good_cnt_reg + 5'h01;
  assign irq = |(istat_reg & imask_reg);
  // Transmit never starts while only listening
  assign link_tx_enable = ~receive_only_listen_mode_reg & ~state_reg[0];
  assign broadcast_fec_rate = broadcast_fec_rate_reg;
  // Only 7-bit frames, only if enabled and the coder reports a gain
  assign huffman_use = huffman_compress_enable_reg & huff_gain & ~tx_frame_has_8bit;
  assign fec_in_ready = ~fec_busy_reg & ~receive_only_listen_mode_reg;
  // ------------------------------------------------------------
  // Wishbone slave: one-cycle ack, unmapped reads return zero
  // ------------------------------------------------------------
  always @(posedge clock) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      wb_dat_o <= 32'h0000_0000;
      if (rd_stb) begin
        case (wb_adr_i)
          `HSC_CTRL_OFS: wb_dat_o <= {28'h0000000, broadcast_fec_rate_reg,
            supervisory_display_enable_reg, receive_only_listen_mode_reg,
            huffman_compress_enable_reg};
          `HSC_CFG0_OFS: wb_dat_o <= {5'h00, fec_char_repeat_count_reg, 4'h0,
            upshift_attempt_limit_reg, 3'h0, good_frame_upshift_threshold_reg, 3'h0,
            bad_frame_downshift_threshold_reg};
          `HSC_CFG1_OFS: wb_dat_o <= {17'h00000, memory_arq_depth_reg,
            link_error_timeout_count_reg};
          `HSC_STAT_OFS: wb_dat_o <= {state_reg, link_speed_200_reg, tries_used_reg,
            1'b0, stored_cnt_reg, 3'h0, good_cnt_reg, bad_cnt_reg};
          `HSC_ISTAT_OFS: wb_dat_o <= {27'h0000000, istat_reg};
          `HSC_IMASK_OFS: wb_dat_o <= {27'h0000000, imask_reg};
          `HSC_COMB_OFS: wb_dat_o <= comb_data_reg[31:0];
          default: wb_dat_o <= 32'h0000_0000; // Unmapped
        endcase
      end
    end
  end
  // ------------------------------------------------------------
  // Settings registers; values written out of range are kept as is
  // ------------------------------------------------------------
  always @(posedge clock) begin
    if (!rst_b) begin
      huffman_compress_enable_reg <= 1'b0;
      receive_only_listen_mode_reg <= 1'b0;
      supervisory_display_enable_reg <= 1'b0;
      broadcast_fec_rate_reg <= 1'b0;
      bad_frame_downshift_threshold_reg <= `HSC_DOWN_RST;
      good_frame_upshift_threshold_reg <= `HSC_UP_RST;
      upshift_attempt_limit_reg <= `HSC_TRIES_RST;
      link_error_timeout_count_reg <= `HSC_ERRS_RST;
      fec_char_repeat_count_reg <= `HSC_RPT_RST;
      memory_arq_depth_reg <= `HSC_ARQ_RST;
      imask_reg <= {`HSC_IRQ_W{1'b0}};
    end else if (wr_stb) begin
      case (wb_adr_i)
        `HSC_CTRL_OFS: begin
          huffman_compress_enable_reg <= wb_dat_i[`HSC_CTRL_HUFF];
          receive_only_listen_mode_reg <= wb_dat_i[`HSC_CTRL_LISTEN];
          supervisory_display_enable_reg <= wb_dat_i[`HSC_CTRL_SUPDISP];
          broadcast_fec_rate_reg <= wb_dat_i[`HSC_CTRL_FEC200];
        end
        `HSC_CFG0_OFS: begin
          bad_frame_downshift_threshold_reg <= wb_dat_i[4:0];
          good_frame_upshift_threshold_reg <= wb_dat_i[12:8];
          upshift_attempt_limit_reg <= wb_dat_i[19:16];
          fec_char_repeat_count_reg <= wb_dat_i[26:24];
        end
        `HSC_CFG1_OFS: begin
          link_error_timeout_count_reg <= wb_dat_i[7:0];
          memory_arq_depth_reg <= wb_dat_i[14:8];
        end
        `HSC_IMASK_OFS: imask_reg <= wb_dat_i[`HSC_IRQ_W-1:0];
        default: imask_reg <= imask_reg; // Read-only or unmapped
      endcase
    end
  end
  // ------------------------------------------------------------
  // Link state, frame counters and speed
  // ------------------------------------------------------------
  always @(posedge clock) begin
    if (!rst_b) begin
      state_reg <= ST_STBY;
      bad_cnt_reg <= 8'h00;
      good_cnt_reg <= 5'h00;
      tries_used_reg <= 4'h0;
      setup_cnt_reg <= 8'h00;
      link_speed_200_reg <= 1'b0;
      upshift_req_reg <= 1'b0;
      ev_next <= {`HSC_IRQ_W{1'b0}};
    end else begin
      upshift_req_reg <= 1'b0;
      ev_next <= {`HSC_IRQ_W{1'b0}};
      case (state_reg)
        ST_STBY: begin
          // Listen mode swallows the start command
          if (start_cmd && !receive_only_listen_mode_reg) begin
            state_reg <= ST_SETUP;
            setup_cnt_reg <= 8'h00;
          end
        end
        ST_SETUP: begin
          if (abort_cmd || receive_only_listen_mode_reg) begin
            state_reg <= ST_STBY;
          end else if (link_answer) begin
            // Links always start at the lower rate
            state_reg <= ST_LINKED;
            link_speed_200_reg <= 1'b0;
            bad_cnt_reg <= 8'h00;
            good_cnt_reg <= 5'h00;
            tries_used_reg <= 4'h0;
          end else if (link_attempt) begin
            if (setup_cnt_reg + 8'h01 >= link_error_timeout_count_reg) begin
              state_reg <= ST_STBY;
              ev_next[`HSC_IRQ_ABAND] <= 1'b1;
            end else begin
              setup_cnt_reg <= setup_cnt_reg + 8'h01;
            end
          end
        end
        ST_LINKED: begin
          if (abort_cmd) begin
            state_reg <= ST_STBY;
            link_speed_200_reg <= 1'b0;
          end else if (bad_frame) begin
            good_cnt_reg <= 5'h00;
            bad_cnt_reg <= bad_cnt_next;
            if (bad_cnt_next >= link_error_timeout_count_reg) begin
              state_reg <= ST_STBY;
              link_speed_200_reg <= 1'b0;
              ev_next[`HSC_IRQ_TMO] <= 1'b1;
            end else if (bad_cnt_next == {3'h0, bad_frame_downshift_threshold_reg} &&
                link_speed_200_reg) begin
              link_speed_200_reg <= 1'b0;
              ev_next[`HSC_IRQ_DOWN] <= 1'b1;
            end
          end else if (good_frame) begin
            bad_cnt_reg <= 8'h00;
            if (good_cnt_next >= good_frame_upshift_threshold_reg) begin
              good_cnt_reg <= 5'h00;
              if (!link_speed_200_reg && tries_used_reg < upshift_attempt_limit_reg) begin
                upshift_req_reg <= 1'b1;
                link_speed_200_reg <= 1'b1;
                tries_used_reg <= tries_used_reg + 4'h1;
                ev_next[`HSC_IRQ_UPREQ] <= 1'b1;
              end else if (!link_speed_200_reg) begin
                // Limit spent: this run only re-arms the attempts
                tries_used_reg <= 4'h0;
              end
            end else begin
              good_cnt_reg <= good_cnt_next;
            end
          end
        end
        default: state_reg <= ST_STBY;
      endcase
    end
  end
  // ------------------------------------------------------------
  // Memory ARQ: keep failed copies and vote bitwise over them
  // ------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < FRAME_W; gi = gi + 1) begin : g_vote
      // Strict majority of stored copies plus the new one
      assign majority[gi] = {{1'b0, ones_cnt_reg[gi]} + {8'h00, frame_data[gi]}, 1'b0} >
        {3'h0, stored_cnt_reg} + 10'h001;
      always @(posedge clock) begin
        if (!rst_b || !linked || (frame_valid && frame_crc_ok) || !frame_repeat &&
            frame_valid) begin
          // A fresh frame restarts the set of copies
          ones_cnt_reg[gi] <= (frame_valid && !frame_crc_ok && linked && rst_b) ?
            {7'h00, frame_data[gi]} : 8'h00;
        end else if (frame_valid && stored_cnt_reg < memory_arq_depth_reg) begin
          ones_cnt_reg[gi] <= ones_cnt_reg[gi] + {7'h00, frame_data[gi]};
        end
      end
    end
  endgenerate
  always @(posedge clock) begin
    if (!rst_b) begin
      stored_cnt_reg <= 7'h00;
      comb_valid_reg <= 1'b0;
      comb_data_reg <= {FRAME_W{1'b0}};
    end else begin
      comb_valid_reg <= 1'b0;
      if (!linked || (frame_valid && frame_crc_ok)) begin
        stored_cnt_reg <= 7'h00;
      end else if (bad_frame && memory_arq_depth_reg != 7'h00) begin
        if (!frame_repeat) begin
          // Failed copy kept instead of dropped
          arq_mem[0] <= frame_data;
          stored_cnt_reg <= 7'h01;
        end else begin
          // Candidate rebuilt from every copy held so far
          comb_data_reg <= majority;
          comb_valid_reg <= 1'b1;
          if (stored_cnt_reg < memory_arq_depth_reg) begin
            arq_mem[stored_cnt_reg] <= frame_data;
            stored_cnt_reg <= stored_cnt_reg + 7'h01;
          end
        end
      end
    end
  end
  // ------------------------------------------------------------
  // Sticky interrupt status; a new event beats a write-one clear
  // ------------------------------------------------------------
  always @(posedge clock) begin
    if (!rst_b) begin
      istat_reg <= {`HSC_IRQ_W{1'b0}};
    end else begin
      istat_reg <= (istat_reg & ~((wr_stb && wb_adr_i == `HSC_ISTAT_OFS) ?
        wb_dat_i[`HSC_IRQ_W-1:0] : {`HSC_IRQ_W{1'b0}})) | ev_next |
        {comb_valid_reg, {(`HSC_IRQ_W-1){1'b0}}};
    end
  end
  // ------------------------------------------------------------
  // Broadcast FEC: each character sent the configured number of times
  // ------------------------------------------------------------
  always @(posedge clock) begin
    if (!rst_b) begin
      fec_busy_reg <= 1'b0;
      fec_left_reg <= 3'h0;
      fec_out_valid_reg <= 1'b0;
      fec_out_data_reg <= 8'h00;
    end else if (fec_in_valid && fec_in_ready) begin
      fec_busy_reg <= 1'b1;
      fec_out_valid_reg <= 1'b1;
      fec_out_data_reg <= fec_in_data;
      fec_left_reg <= fec_char_repeat_count_reg;
    end else if (fec_out_valid_reg && fec_out_ready) begin
      if (fec_left_reg <= 3'h1) begin
        fec_busy_reg <= 1'b0;
        fec_out_valid_reg <= 1'b0;
        fec_left_reg <= 3'h0;
      end else begin
        fec_left_reg <= fec_left_reg - 3'h1;
      end
    end
  end
  // ------------------------------------------------------------
  // Supervisory report to the host, gated by its enable
  // ------------------------------------------------------------
  always @(posedge clock) begin
    if (!rst_b) begin
      sup_out_valid_reg <= 1'b0;
      sup_out_data_reg <= 8'h00;
    end else begin
      sup_out_valid_reg <= sup_valid & supervisory_display_enable_reg;
      sup_out_data_reg <= sup_data;
    end
  end
endmodule // hsc_link_ctrl

// ===== tb/hsc_link_monitor.sv
// Port-level assertion checker for the link speed controller
`timescale 1ns/1ps
module hsc_link_monitor (
  input wire clock,
  input wire rst_b,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  input wire link_speed_200_reg,
  input wire upshift_req_reg,
  input wire frame_valid,
  input wire frame_crc_ok,
  input wire frame_repeat,
  input wire comb_valid_reg,
  input wire sup_valid,
  input wire [7:0] sup_data,
  input wire sup_out_valid_reg,
  input wire [7:0] sup_out_data_reg,
  input wire tx_frame_has_8bit,
  input wire huff_gain,
  input wire huffman_use,
  input wire fec_in_valid,
  input wire fec_in_ready,
  input wire [7:0] fec_in_data,
  input wire fec_out_valid_reg,
  input wire [7:0] fec_out_data_reg
);
  // ------------------------------------------------------------
  // Shared clocking and the two request steps
  // ------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  // Request still waiting for its answer
  sequence s_bus_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  // Character accepted into the repeater
  sequence s_fec_take;
    fec_in_valid && fec_in_ready;
  endsequence
  AST_ACK_NEXT: assert property (s_bus_take |=> wb_ack_o)
    else $error("no ack after request");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_DOWN_CAUSE: assert property (
    $fell(link_speed_200_reg) |-> $past(frame_valid && !frame_crc_ok))
    else $error("downshift without bad frame");
  AST_UP_CAUSE: assert property (
    upshift_req_reg |-> link_speed_200_reg && !$past(link_speed_200_reg)
      && $past(frame_valid && frame_crc_ok))
    else $error("upshift without good frame");
  AST_SUP_PASS: assert property (
    sup_out_valid_reg |-> $past(sup_valid) && sup_out_data_reg == $past(sup_data))
    else $error("supervisory output mismatch");
  AST_NO_HUFF_8BIT: assert property (tx_frame_has_8bit |-> !huffman_use)
    else $error("8-bit frame compressed");
  AST_HUFF_GAIN: assert property (huffman_use |-> huff_gain)
    else $error("compressed without gain");
  AST_FEC_FIRST: assert property (
    s_fec_take |=> fec_out_valid_reg && fec_out_data_reg == $past(fec_in_data))
    else $error("accepted character not shown");
  AST_COMB_CAUSE: assert property (
    comb_valid_reg |-> $past(frame_valid && !frame_crc_ok && frame_repeat))
    else $error("combine without repeated bad frame");
endmodule // hsc_link_monitor

// ===== tb/hsc_remote_model.sv
// Remote station model: received frames, setup events and a stalling FEC sink
`timescale 1ns/1ps
module hsc_remote_model (
  input wire clock,
  output logic frame_valid = 1'b0,
  output logic frame_crc_ok = 1'b0,
  output logic frame_repeat = 1'b0,
  output logic [31:0] frame_data = 32'h0,
  output logic link_attempt = 1'b0,
  output logic link_answer = 1'b0,
  output logic fec_out_ready = 1'b0
);
  // One frame; qualifiers scrambled afterwards
  task frame(input logic ok, input logic rep, input logic [31:0] d);
    @(posedge clock);
    frame_valid <= 1'b1;
    frame_crc_ok <= ok;
    frame_repeat <= rep;
    frame_data <= d;
    @(posedge clock);
    frame_valid <= 1'b0;
    frame_crc_ok <= ~ok;
    frame_repeat <= ~rep;
    frame_data <= ~d;
  endtask
  // Unanswered attempt or an answer, one cycle each
  task setup_event(input logic ans);
    @(posedge clock);
    if (ans) begin
      link_answer <= 1'b1;
    end else begin
      link_attempt <= 1'b1;
    end
    @(posedge clock);
    link_answer <= 1'b0;
    link_attempt <= 1'b0;
  endtask
  // Sink stalls a quarter of the time
  always @(posedge clock) begin
    fec_out_ready <= ($urandom_range(3) != 0);
  end
endmodule // hsc_remote_model

// ===== tb/tb_hsc_link_ctrl.sv
// Self-checking bench for the link speed controller
`timescale 1ns/1ps
`include "hsc_regs.vh"
module tb_hsc_link_ctrl;
  // ------------------------------------------------------------
  // Stimulus, design outputs and bookkeeping
  // ------------------------------------------------------------
  logic clock = 1'b0, rst_b = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00, fec_in_data = 8'h00, sup_data = 8'h00, d;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, fa, fb, fc;
  logic fec_in_valid = 1'b0, sup_valid = 1'b0, tx_frame_has_8bit = 1'b0, huff_gain = 1'b0;
  logic spd_d = 1'b0;
  wire [31:0] wb_dat_o, frame_data, comb_data_reg;
  wire [7:0] fec_out_data_reg, sup_out_data_reg;
  wire wb_ack_o, irq, link_tx_enable, link_speed_200_reg, upshift_req_reg, comb_valid_reg;
  wire huffman_use, broadcast_fec_rate, fec_in_ready, fec_out_valid_reg, sup_out_valid_reg;
  wire frame_valid, frame_crc_ok, frame_repeat, link_attempt, link_answer, fec_out_ready;
  logic [63:0] exq[4][$]; // Notes {mask, value}: 0 speed, 1 combine, 2 FEC, 3 supervisory
  integer errors = 0, samples_checked = 0, i, n;
  hsc_link_ctrl uut (.clock, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq, .frame_valid, .frame_crc_ok, .frame_repeat,
    .frame_data, .link_attempt, .link_answer, .link_tx_enable, .link_speed_200_reg,
    .upshift_req_reg, .comb_valid_reg, .comb_data_reg, .tx_frame_has_8bit, .huff_gain,
    .huffman_use, .broadcast_fec_rate, .fec_in_valid, .fec_in_data, .fec_in_ready,
    .fec_out_valid_reg, .fec_out_data_reg, .fec_out_ready, .sup_valid, .sup_data,
    .sup_out_valid_reg, .sup_out_data_reg);
  hsc_remote_model remote (.clock, .frame_valid, .frame_crc_ok, .frame_repeat, .frame_data,
    .link_attempt, .link_answer, .fec_out_ready);
  always #2 clock = ~clock;
  // ------------------------------------------------------------
  // Compare, verdict and bus tasks
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("Error %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task stop_test;
    if (errors == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task fail;
    errors++;
    stop_test;
  endtask
  // Oldest note; empty queue forces a mismatch
  task automatic take(input logic [1:0] k, input logic [31:0] seen);
    logic [63:0] e;
    if (exq[k].size() == 0) e = 64'h1; else e = exq[k].pop_front();
    check(seen & e[63:32], e[31:0]);
  endtask
  // Classic single cycle, held until ack is sampled high
  task wb(input logic w, input logic [7:0] a, input logic [31:0] dt, input logic [3:0] s = 4'hf);
    @(posedge clock);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= dt;
    wb_sel_i <= s;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) fail();
    fa = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m = 32'hffffffff);
    wb(1'b0, a, 32'h0);
    check(fa & m, exp);
  endtask
  task frames(input integer k, input logic ok);
    repeat (k) remote.frame(ok, 1'b0, $urandom);
  endtask
  // Watcher: every result taken against the oldest note
  always @(posedge clock) begin
    spd_d <= link_speed_200_reg;
    if (rst_b === 1'b1 && link_speed_200_reg !== spd_d)
      take(0, {30'h0, upshift_req_reg, link_speed_200_reg});
    if (comb_valid_reg === 1'b1) take(1, comb_data_reg);
    if (fec_out_valid_reg === 1'b1 && fec_out_ready === 1'b1) take(2, {24'h0, fec_out_data_reg});
    if (sup_out_valid_reg === 1'b1) take(3, {24'h0, sup_out_data_reg});
  end
  initial begin
    repeat (100000) @(posedge clock);
    fail();
  end
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(32'h65095b46));
    repeat (8) @(posedge clock);
    rst_b <= 1'b1;
    wb(1'b1, `HSC_CFG0_OFS, 32'h0, 4'he); // Lane 0 clear: write must be ignored
    rd(`HSC_CFG0_OFS, 32'h02020306);
    rd(`HSC_CFG1_OFS, 32'h00000550);
    rd(`HSC_STAT_OFS, 32'h20000000);
    rd(8'h1c, 32'h0);
    check({31'h0, broadcast_fec_rate}, 32'h0);
    // Setup abandoned at the attempt count; interrupt path
    wb(1'b1, `HSC_CFG1_OFS, 32'h0000051e);
    wb(1'b1, `HSC_CTRL_OFS, 32'h10);
    check({31'h0, link_tx_enable}, 32'h1);
    repeat (29) remote.setup_event(1'b0);
    rd(`HSC_STAT_OFS, 32'h40000000, 32'he0000000);
    remote.setup_event(1'b0);
    rd(`HSC_STAT_OFS, 32'h20000000, 32'he0000000);
    rd(`HSC_ISTAT_OFS, 32'h8, 32'h8);
    check({31'h0, irq}, 32'h0);
    wb(1'b1, `HSC_IMASK_OFS, 32'h1f);
    @(posedge clock);
    check({31'h0, irq}, 32'h1);
    wb(1'b1, `HSC_ISTAT_OFS, 32'h1f);
    @(posedge clock);
    check({31'h0, irq}, 32'h0);
    // Linked: speed walk, counter clears, try limit
    wb(1'b1, `HSC_CTRL_OFS, 32'h10);
    remote.setup_event(1'b1);
    rd(`HSC_STAT_OFS, 32'h80000000, 32'he0000000);
    exq[0].push_back({32'h3, 32'h3});
    frames(3, 1'b1);
    frames(5, 1'b0);
    frames(1, 1'b1);
    frames(5, 1'b0);
    exq[0].push_back({32'h3, 32'h0});
    frames(1, 1'b0);
    frames(2, 1'b1);
    frames(1, 1'b0);
    exq[0].push_back({32'h3, 32'h3});
    frames(3, 1'b1);
    exq[0].push_back({32'h3, 32'h0});
    frames(6, 1'b0);
    frames(3, 1'b1);
    exq[0].push_back({32'h3, 32'h3});
    frames(3, 1'b1);
    exq[0].push_back({32'h3, 32'h0});
    frames(6, 1'b0);
    // Memory ARQ, then timeout at the error count
    frames(1, 1'b1);
    fa = $urandom;
    fb = $urandom;
    fc = $urandom;
    exq[1].push_back({32'h0, 32'h0});
    exq[1].push_back({32'hffffffff, (fa & fb) | (fa & fc) | (fb & fc)});
    remote.frame(1'b0, 1'b0, fa);
    remote.frame(1'b0, 1'b1, fb);
    remote.frame(1'b0, 1'b1, fc);
    frames(26, 1'b0);
    rd(`HSC_STAT_OFS, 32'h80000000, 32'he0000000);
    frames(1, 1'b0);
    rd(`HSC_STAT_OFS, 32'h20000000, 32'he0000000);
    rd(`HSC_ISTAT_OFS, 32'h14, 32'h14);
    check({31'h0, irq}, 32'h1);
    frames(3, 1'b1); // Outside the link: no speed change expected
    // FEC at 200, each character sent three times
    wb(1'b1, `HSC_CFG0_OFS, 32'h03020306);
    wb(1'b1, `HSC_CTRL_OFS, 32'h08);
    check({31'h0, broadcast_fec_rate}, 32'h1);
    for (i = 0; i < 2; i++) begin
      d = $urandom;
      repeat (3) exq[2].push_back({32'hff, 24'h0, d});
      @(posedge clock);
      fec_in_valid <= 1'b1;
      fec_in_data <= d;
      n = 0;
      do begin
        @(posedge clock);
        n++;
      end while (fec_in_ready !== 1'b1 && n < 50);
      if (fec_in_ready !== 1'b1) fail();
      fec_in_valid <= 1'b0;
      fec_in_data <= ~d;
    end
    // Compression over every input combination
    for (i = 0; i < 8; i++) begin
      wb(1'b1, `HSC_CTRL_OFS, {31'h0, i[2]});
      huff_gain <= i[1];
      tx_frame_has_8bit <= i[0];
      @(posedge clock);
      check({31'h0, huffman_use}, {31'h0, i[2] & i[1] & ~i[0]});
    end
    // Supervisory data passes only when enabled
    for (i = 0; i < 2; i++) begin
      wb(1'b1, `HSC_CTRL_OFS, {29'h0, i[0], 2'h0});
      d = $urandom;
      if (i == 1) exq[3].push_back({32'hff, 24'h0, d});
      @(posedge clock);
      sup_valid <= 1'b1;
      sup_data <= d;
      @(posedge clock);
      sup_valid <= 1'b0;
      sup_data <= ~d;
      repeat (3) @(posedge clock);
    end
    // Listen mode refuses link start and FEC input
    wb(1'b1, `HSC_CTRL_OFS, 32'h02);
    wb(1'b1, `HSC_CTRL_OFS, 32'h12);
    rd(`HSC_STAT_OFS, 32'h20000000, 32'he0000000);
    check({30'h0, link_tx_enable, fec_in_ready}, 32'h0);
    repeat (300) @(posedge clock);
    if (exq[0].size() + exq[1].size() + exq[2].size() + exq[3].size() != 0) fail();
    stop_test();
  end
endmodule // tb_hsc_link_ctrl
bind hsc_link_ctrl hsc_link_monitor u_mon (.clock, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
  .link_speed_200_reg, .upshift_req_reg, .frame_valid, .frame_crc_ok, .frame_repeat,
  .comb_valid_reg, .sup_valid, .sup_data, .sup_out_valid_reg, .sup_out_data_reg,
  .tx_frame_has_8bit, .huff_gain, .huffman_use, .fec_in_valid, .fec_in_ready, .fec_in_data,
  .fec_out_valid_reg, .fec_out_data_reg);
